// [design/wwc_pkg.sv]
// shared constants, types and helpers of the windowed watchdog control block
package wwc_pkg;

    // ==========================================================
    // register map: printed offsets are word indices, byte address = 4 * index
    localparam int unsigned AXI_AW = 8;
    localparam logic [5:0] CTRL_IDX = 6'h00;
    localparam logic [5:0] STATUS_IDX = 6'h01;

    // ==========================================================
    // field layout
    localparam int unsigned WIN_MSB = 7;
    localparam int unsigned WIN_LSB = 4;
    localparam int unsigned PER_MSB = 3;
    localparam int unsigned PER_LSB = 0;
    localparam int unsigned LOCK_BIT = 7;
    localparam int unsigned BUSY_BIT = 0;

    // ==========================================================
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;

    // ==========================================================
    // duration codes, in watchdog oscillator cycles
    localparam logic [3:0] CODE_OFF = 4'h0;
    localparam logic [3:0] CODE_LONGEST = 4'hb;
    localparam logic [13:0] DUR_BASE = 14'h0008;
    localparam logic [13:0] DUR_LONGEST = 14'h2000;

    // ==========================================================
    // crossing counts: value of the tick counter on the applying tick
    localparam logic SYNC_LAST = 1'b1;
    localparam logic CLR_LAST = 1'b1;

    // ==========================================================
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        WWC_OFF = 2'b00,
        WWC_OPEN = 2'b01,
        WWC_CLOSED = 2'b10
    } wwc_state_e;

    // reserved codes run as the longest duration rather than stopping the dog
    function automatic logic [13:0] wwc_dur(input logic [3:0] code);
        if (code == CODE_OFF)
        begin
            return 14'h0000;
        end
        else if (code > CODE_LONGEST)
        begin
            return DUR_LONGEST;
        end
        else
        begin
            return DUR_BASE << (code - 4'h1);
        end
    endfunction

endpackage

// [design/wwc_osc_sync.sv]
// two-stage synchroniser and rising-edge tick for the watchdog oscillator input
`timescale 1ns/1ps
`default_nettype none
module wwc_osc_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic osc_in,
    output logic tick
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // ==========================================================
    // synchroniser: meta_r is read by sync_r only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else if (ce)
        begin
            meta_r <= osc_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign tick = sync_r & ~prev_r;

endmodule
`default_nettype wire

// [design/wwc_axil.sv]
// axi4-lite slave front end of the watchdog control registers
`timescale 1ns/1ps
`default_nettype none
module wwc_axil (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [wwc_pkg::AXI_AW-1:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [wwc_pkg::AXI_AW-1:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    output logic reg_we,
    output logic [5:0] reg_widx,
    output logic [7:0] reg_wdata,
    output logic [5:0] reg_ridx,
    input wire logic [7:0] reg_rdata
);
    import wwc_pkg::*;

    logic [AXI_AW-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic strb0_r;
    logic wr_go;
    logic aw_hit;
    logic ar_hit;

    function automatic logic addr_hit(input logic [AXI_AW-1:0] a);
        return (a[1:0] == 2'h0) && (a[AXI_AW-1:2] == CTRL_IDX || a[AXI_AW-1:2] == STATUS_IDX);
    endfunction

    // ==========================================================
    // decode
    assign aw_hit = addr_hit(awaddr_r);
    assign ar_hit = addr_hit(s_axil_araddr);
    assign wr_go = !s_axil_awready && !s_axil_wready && !s_axil_bvalid;
    assign reg_widx = awaddr_r[AXI_AW-1:2];
    assign reg_wdata = wdata_r[7:0];
    assign reg_ridx = s_axil_araddr[AXI_AW-1:2];

    // ==========================================================
    // write channel: address and data in either order, one write in flight
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axil_awready <= 1'b1;
            s_axil_wready <= 1'b1;
            s_axil_bvalid <= 1'b0;
            s_axil_bresp <= RESP_OKAY;
            awaddr_r <= '0;
            wdata_r <= 32'h0000_0000;
            strb0_r <= 1'b0;
            reg_we <= 1'b0;
        end
        else if (ce)
        begin
            reg_we <= 1'b0;
            if (s_axil_awvalid && s_axil_awready)
            begin
                s_axil_awready <= 1'b0;
                awaddr_r <= s_axil_awaddr;
            end
            if (s_axil_wvalid && s_axil_wready)
            begin
                s_axil_wready <= 1'b0;
                wdata_r <= s_axil_wdata;
                strb0_r <= s_axil_wstrb[0];
            end
            if (wr_go)
            begin
                s_axil_bvalid <= 1'b1;
                s_axil_bresp <= aw_hit ? RESP_OKAY : RESP_SLVERR;
                reg_we <= aw_hit && strb0_r;
            end
            if (s_axil_bvalid && s_axil_bready)
            begin
                s_axil_bvalid <= 1'b0;
                s_axil_awready <= 1'b1;
                s_axil_wready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // read channel: data captured at the address handshake
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axil_arready <= 1'b1;
            s_axil_rvalid <= 1'b0;
            s_axil_rdata <= 32'h0000_0000;
            s_axil_rresp <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axil_arvalid && s_axil_arready)
            begin
                s_axil_arready <= 1'b0;
                s_axil_rvalid <= 1'b1;
                s_axil_rdata <= {24'h00_0000, ar_hit ? reg_rdata : 8'h00};
                s_axil_rresp <= ar_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axil_rvalid && s_axil_rready)
            begin
                s_axil_rvalid <= 1'b0;
                s_axil_arready <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// [design/wwc_top.sv]
// windowed watchdog control, lock, crossing and timeout logic
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module wwc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [wwc_pkg::AXI_AW-1:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [wwc_pkg::AXI_AW-1:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic watchdog_osc_clock,
    input wire logic watchdog_clear_instruction,
    input wire logic protected_write_unlock,
    input wire logic debug_mode,
    input wire logic boot_cfg_load,
    input wire logic [7:0] boot_watchdog_config,
    output logic sys_reset_req
);
    import wwc_pkg::*;

    logic reg_we;
    logic [5:0] reg_widx;
    logic [7:0] reg_wdata;
    logic [5:0] reg_ridx;
    logic [7:0] reg_rdata;
    logic osc_tick;

    logic [7:0] timing_control_reg_r;
    logic [7:0] act_ctrl_r;
    logic lock_r;
    logic sync_pending_flag_r;
    logic sync_cnt_r;
    logic clr_pend_r;
    logic clr_cnt_r;
    wwc_state_e state_r;
    wwc_state_e state_nxt;
    logic [13:0] cnt_r;
    logic [13:0] cnt_nxt;
    logic rst_req_r;
    logic rst_nxt;

    // ==========================================================
    // bus front end and oscillator tick
    wwc_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .s_axil_awaddr(s_axil_awaddr),
        .s_axil_awvalid(s_axil_awvalid),
        .s_axil_awready(s_axil_awready),
        .s_axil_wdata(s_axil_wdata),
        .s_axil_wstrb(s_axil_wstrb),
        .s_axil_wvalid(s_axil_wvalid),
        .s_axil_wready(s_axil_wready),
        .s_axil_bresp(s_axil_bresp),
        .s_axil_bvalid(s_axil_bvalid),
        .s_axil_bready(s_axil_bready),
        .s_axil_araddr(s_axil_araddr),
        .s_axil_arvalid(s_axil_arvalid),
        .s_axil_arready(s_axil_arready),
        .s_axil_rdata(s_axil_rdata),
        .s_axil_rresp(s_axil_rresp),
        .s_axil_rvalid(s_axil_rvalid),
        .s_axil_rready(s_axil_rready),
        .reg_we(reg_we),
        .reg_widx(reg_widx),
        .reg_wdata(reg_wdata),
        .reg_ridx(reg_ridx),
        .reg_rdata(reg_rdata)
    );

    wwc_osc_sync u_osc_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .osc_in(watchdog_osc_clock),
        .tick(osc_tick)
    );

    // ==========================================================
    // register decode
    wire ctrl_hit = reg_we && (reg_widx == CTRL_IDX);
    wire stat_hit = reg_we && (reg_widx == STATUS_IDX);
    // control writes while busy are dropped so a crossing never sees a torn value
    wire ctrl_we = ctrl_hit && protected_write_unlock && !lock_r && !sync_pending_flag_r;
    wire stat_we = stat_hit && protected_write_unlock;
    wire boot_per_on = boot_watchdog_config[PER_MSB:PER_LSB] != CODE_OFF;
    wire lock_set = (stat_we && reg_wdata[LOCK_BIT]) || (boot_cfg_load && boot_per_on);
    wire lock_clr = stat_we && !reg_wdata[LOCK_BIT] && debug_mode;
    wire cfg_load = ctrl_we || boot_cfg_load;
    wire [7:0] cfg_val = boot_cfg_load ? boot_watchdog_config : reg_wdata;
    wire [7:0] status_word = STATUS_RST | ({7'h00, lock_r} << LOCK_BIT)
        | ({7'h00, sync_pending_flag_r} << BUSY_BIT);
    assign reg_rdata = (reg_ridx == CTRL_IDX) ? timing_control_reg_r
        : (reg_ridx == STATUS_IDX) ? status_word : 8'h00;

    // ==========================================================
    // crossing of the control value into the oscillator timebase
    wire busy_done = sync_pending_flag_r && osc_tick && (sync_cnt_r == SYNC_LAST);
    wire [3:0] act_per = act_ctrl_r[PER_MSB:PER_LSB];
    wire [3:0] act_win = act_ctrl_r[WIN_MSB:WIN_LSB];
    wire [13:0] per_dur = wwc_dur(act_per);
    wire [13:0] win_dur = wwc_dur(act_win);
    wire [13:0] cnt_inc = cnt_r + 14'h0001;

    // ==========================================================
    // clear instruction crossing
    wire clr_take = watchdog_clear_instruction && !clr_pend_r;
    wire clr_apply = clr_pend_r && osc_tick && (clr_cnt_r == CLR_LAST);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            timing_control_reg_r <= CTRL_RST;
            act_ctrl_r <= CTRL_RST;
            lock_r <= STATUS_RST[LOCK_BIT];
            sync_pending_flag_r <= STATUS_RST[BUSY_BIT];
            sync_cnt_r <= 1'b0;
        end
        else if (ce)
        begin
            if (cfg_load)
            begin
                timing_control_reg_r <= cfg_val;
            end
            lock_r <= lock_set | (lock_r & ~lock_clr);
            // a fresh load wins over a finishing crossing
            sync_pending_flag_r <= cfg_load | (sync_pending_flag_r & ~busy_done);
            if (cfg_load)
            begin
                sync_cnt_r <= 1'b0;
            end
            else if (sync_pending_flag_r && osc_tick)
            begin
                sync_cnt_r <= ~sync_cnt_r;
            end
            if (busy_done)
            begin
                act_ctrl_r <= timing_control_reg_r;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            clr_pend_r <= 1'b0;
            clr_cnt_r <= 1'b0;
        end
        else if (ce)
        begin
            clr_pend_r <= clr_take | (clr_pend_r & ~clr_apply);
            if (clr_take)
            begin
                clr_cnt_r <= 1'b0;
            end
            else if (clr_pend_r && osc_tick)
            begin
                clr_cnt_r <= ~clr_cnt_r;
            end
        end
    end

    // ==========================================================
    // timeout state machine
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        rst_nxt = 1'b0;
        if (act_per == CODE_OFF)
        begin
            state_nxt = WWC_OFF;
            cnt_nxt = 14'h0000;
        end
        else if (debug_mode || busy_done)
        begin
            state_nxt = WWC_OPEN;
            cnt_nxt = 14'h0000;
        end
        else
        begin
            unique case (state_r)
                WWC_OFF:
                begin
                    state_nxt = WWC_OPEN;
                    cnt_nxt = 14'h0000;
                end
                WWC_OPEN:
                begin
                    if (clr_apply)
                    begin
                        cnt_nxt = 14'h0000;
                        state_nxt = (act_win != CODE_OFF) ? WWC_CLOSED : WWC_OPEN;
                    end
                    else if (osc_tick && cnt_inc == per_dur)
                    begin
                        rst_nxt = 1'b1;
                        cnt_nxt = 14'h0000;
                    end
                    else if (osc_tick)
                    begin
                        cnt_nxt = cnt_inc;
                    end
                end
                WWC_CLOSED:
                begin
                    if (clr_apply)
                    begin
                        rst_nxt = 1'b1;
                        state_nxt = WWC_OPEN;
                        cnt_nxt = 14'h0000;
                    end
                    else if (act_win == CODE_OFF || (osc_tick && cnt_inc == win_dur))
                    begin
                        state_nxt = WWC_OPEN;
                        cnt_nxt = 14'h0000;
                    end
                    else if (osc_tick)
                    begin
                        cnt_nxt = cnt_inc;
                    end
                end
                default:
                begin
                    state_nxt = WWC_OFF;
                    cnt_nxt = 14'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= WWC_OFF;
            cnt_r <= 14'h0000;
            rst_req_r <= 1'b0;
        end
        else if (ce)
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            rst_req_r <= rst_nxt;
        end
    end

    assign sys_reset_req = rst_req_r;

    // ==========================================================
    // assertions
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    wire run_ok = ce && act_per != CODE_OFF && !debug_mode && !busy_done;

    AST_LOCK_STICKY: assert property (lock_r && !debug_mode |=> lock_r)
        else $error("lock cleared outside debug mode");
    AST_LOCK_DEBUG: assert property ($fell(lock_r) |-> $past(debug_mode))
        else $error("lock fell without debug mode");
    AST_LOCK_FREEZE: assert property ($changed(timing_control_reg_r)
        |-> !$past(lock_r) || $past(boot_cfg_load))
        else $error("control changed while locked");
    AST_BOOT_LOCK: assert property (ce && boot_cfg_load && boot_per_on |=> lock_r)
        else $error("boot period did not set lock");
    AST_LOCK_CCP: assert property ($rose(lock_r)
        |-> $past(protected_write_unlock) || $past(boot_cfg_load))
        else $error("lock set without unlock sequence");
    AST_BUSY_SET: assert property (ce && cfg_load |=> sync_pending_flag_r)
        else $error("busy not raised after control write");
    AST_BUSY_CLR: assert property (ce && busy_done && !cfg_load
        |=> !sync_pending_flag_r && act_ctrl_r == $past(timing_control_reg_r))
        else $error("crossing end did not clear busy and apply value");
    AST_OFF: assert property (ce && act_per == CODE_OFF
        |=> state_r == WWC_OFF && !rst_req_r)
        else $error("watchdog active with period off");
    AST_TIMEOUT: assert property (run_ok && state_r == WWC_OPEN && !clr_apply
        && osc_tick && cnt_inc == per_dur |=> rst_req_r && cnt_r == 14'h0000)
        else $error("timeout did not request reset");
    AST_CLOSED_CLR: assert property (run_ok && state_r == WWC_CLOSED && clr_apply
        |=> rst_req_r && state_r == WWC_OPEN)
        else $error("clear in closed period did not request reset");
    AST_WIN_ENTRY: assert property (run_ok && state_r == WWC_OPEN && clr_apply
        && act_win != CODE_OFF |=> state_r == WWC_CLOSED && !rst_req_r)
        else $error("clear in open period did not start closed period");
    AST_FIRST_OPEN: assert property (ce && debug_mode && act_per != CODE_OFF
        |=> state_r == WWC_OPEN && cnt_r == 14'h0000)
        else $error("debug did not reset to open period");
    AST_CLR_IGN: assert property (ce && clr_pend_r && !osc_tick
        |=> clr_pend_r && $stable(clr_cnt_r))
        else $error("pending clear restarted or lost");

    COV_TIMEOUT: cover property (run_ok && state_r == WWC_OPEN ##1 rst_req_r);
    COV_CLOSED_CLR: cover property (state_r == WWC_CLOSED && clr_apply ##1 rst_req_r);
    COV_WINDOW: cover property (state_r == WWC_CLOSED ##[1:1000] state_r == WWC_OPEN);
    COV_LOCK: cover property ($rose(lock_r));

endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench of the windowed watchdog control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import wwc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, bcfg = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic osc = 1'b0, clr = 1'b0, unl = 1'b0, dbg = 1'b0, bload = 1'b0;
    logic ce_in = 1'b1;
    logic awr, wr, bv, arr, rv, rst_req;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] osc_cnt = 3'h0;
    int mismatches = 0;
    int check_count = 0;
    // ==========================================================
    // clocks: the oscillator runs at an eighth of aclk to keep the run short
    always #5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        osc_cnt <= osc_cnt + 3'h1;
        osc <= osc_cnt[2];
    end
    wwc_top u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce_in),
        .s_axil_awaddr(awaddr), .s_axil_awvalid(awv), .s_axil_awready(awr),
        .s_axil_wdata(wdata), .s_axil_wstrb(4'h1), .s_axil_wvalid(wv), .s_axil_wready(wr),
        .s_axil_bresp(bresp), .s_axil_bvalid(bv), .s_axil_bready(br),
        .s_axil_araddr(araddr), .s_axil_arvalid(arv), .s_axil_arready(arr),
        .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rv), .s_axil_rready(rr),
        .watchdog_osc_clock(osc), .watchdog_clear_instruction(clr),
        .protected_write_unlock(unl), .debug_mode(dbg), .boot_cfg_load(bload),
        .boot_watchdog_config(bcfg), .sys_reset_req(rst_req));
    // ==========================================================
    // expectations and reporting
    function automatic logic [31:0] stat(input logic l, input logic b);
        return {24'h0, l, 6'h00, b};
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic timed_out();
        mismatches++;
        $display("mismatch wait expected done seen timeout");
        report_and_stop();
    endtask
    // ==========================================================
    // bus cycles: unlock is held for the whole write so the apply cycle sees it
    task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic u,
        output logic [1:0] resp);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        resp = 2'h3;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        unl <= u;
        while (!done && n < 64)
        begin
            @(posedge aclk);
            n++;
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
            if (bv === 1'b1)
            begin
                resp = bresp;
                br <= 1'b0;
                unl <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) timed_out();
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        while (!done && n < 64)
        begin
            @(posedge aclk);
            n++;
            if (arv && arr) arv <= 1'b0;
            if (rv === 1'b1)
            begin
                d = rdata;
                resp = rresp;
                rr <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) timed_out();
    endtask
    task automatic wrt(input logic [7:0] a, input logic [7:0] d, input logic u);
        logic [1:0] r;
        axi_write(a, d, u, r);
        check_val("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask
    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check_val(what, exp, d);
        check_val("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask
    task automatic wait_idle();
        logic [31:0] d;
        logic [1:0] r;
        int n;
        n = 0;
        d = 32'h1;
        while (d[0] !== 1'b0 && n < 40)
        begin
            axi_read(8'h04, d, r);
            n++;
        end
        if (d[0] !== 1'b0) timed_out();
    endtask
    task automatic wait_rst(input int lim, output int c);
        c = 0;
        while (rst_req !== 1'b1 && c < lim)
        begin
            @(posedge aclk);
            c++;
        end
    endtask
    task automatic pulse(input logic boot);
        @(posedge aclk);
        if (boot)
            bload <= 1'b1;
        else
            clr <= 1'b1;
        @(posedge aclk);
        bload <= 1'b0;
        clr <= 1'b0;
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] v;
        int c;
        void'($urandom(32'h0cc9));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd_check(8'h04, stat(0, 0), "status reset");
        rd_check(8'h00, {24'h0, CTRL_RST}, "ctrl reset");
        axi_write(8'h08, 8'h11, 1'b1, r);
        check_val("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        axi_read(8'h02, d, r);
        check_val("misaligned rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        v = 8'h00;
        repeat (6)
        begin
            v = {4'($urandom_range(11)), 4'($urandom_range(11))};
            wrt(8'h00, v, 1'b1);
            rd_check(8'h04, stat(0, 1), "busy after write");
            wait_idle();
            rd_check(8'h00, {24'h0, v}, "ctrl value");
        end
        wrt(8'h00, ~v, 1'b0);
        rd_check(8'h00, {24'h0, v}, "ctrl without unlock");
        wrt(8'h04, 8'h01, 1'b1);
        rd_check(8'h04, stat(0, 0), "busy not writable");
        // shortest period: 8 ticks of 8 cycles each, no clear
        wrt(8'h00, 8'h01, 1'b1);
        wait_idle();
        wait_rst(400, c);
        check_val("timeout", 32'h1, {31'h0, rst_req === 1'b1 && c >= 40 && c <= 88});
        c = 0;
        for (int i = 0; i < 320; i++)
        begin
            @(posedge aclk);
            clr <= (i % 32 == 0);
            if (rst_req === 1'b1) c++;
        end
        check_val("reset while cleared", 32'h0, 32'(c));
        wrt(8'h00, 8'h00, 1'b1);
        wait_idle();
        wrt(8'h00, 8'h11, 1'b1);
        wait_idle();
        pulse(1'b0);
        wait_rst(40, c);
        check_val("first clear opens", 32'd40, 32'(c));
        pulse(1'b0);
        wait_rst(60, c);
        check_val("clear in closed", 32'h1, {31'h0, rst_req});
        wrt(8'h00, 8'h00, 1'b1);
        // ce low must hold the crossing: busy still up after the pause
        ce_in <= 1'b0;
        repeat (100) @(posedge aclk);
        ce_in <= 1'b1;
        rd_check(8'h04, stat(0, 1), "busy frozen by ce");
        wait_idle();
        wrt(8'h04, 8'h80, 1'b0);
        rd_check(8'h04, stat(0, 0), "lock without unlock");
        wrt(8'h04, 8'h80, 1'b1);
        rd_check(8'h04, stat(1, 0), "lock set");
        wrt(8'h00, 8'h22, 1'b1);
        rd_check(8'h00, 32'h0, "ctrl locked");
        wrt(8'h04, 8'h00, 1'b1);
        rd_check(8'h04, stat(1, 0), "lock kept");
        dbg <= 1'b1;
        wrt(8'h04, 8'h00, 1'b1);
        dbg <= 1'b0;
        rd_check(8'h04, stat(0, 0), "lock cleared in debug");
        bcfg <= 8'h30;
        pulse(1'b1);
        wait_idle();
        rd_check(8'h04, stat(0, 0), "boot without period");
        bcfg <= 8'h03;
        pulse(1'b1);
        wait_idle();
        rd_check(8'h04, stat(1, 0), "boot lock");
        rd_check(8'h00, 32'h03, "boot ctrl");
        report_and_stop();
    end
endmodule
`default_nettype wire
